// >>> verilog/usb_suspend_remote_wake_ctrl.v
// Purpose: USB suspend/resume, power attribute, remote wake and radio gating
// Assumes: bus_suspend/bus_resume/tx_ready/radio_evt are asynchronous pins
// Notes:   registers over AXI4-Lite; one level interrupt output
`timescale 1ns/1ps
`include "usb_pm_map.vh"

module usb_suspend_remote_wake_ctrl #(
  parameter DW          = 8,
  parameter DEPTH       = 8,
  parameter AW          = 3,
  parameter SCAN_PERIOD = `SCAN_PERIOD_CYC
) (
  input  wire          clock,          // 125 MHz system clock
  input  wire          nrst,           // Async reset, active low
  input  wire [13:0]   s_axi_awaddr,   // Write address
  input  wire          s_axi_awvalid,  // Write address valid
  output reg           s_axi_awready,  // Write address ready
  input  wire [31:0]   s_axi_wdata,    // Write data
  input  wire [3:0]    s_axi_wstrb,    // Write strobes
  input  wire          s_axi_wvalid,   // Write data valid
  output reg           s_axi_wready,   // Write data ready
  output reg  [1:0]    s_axi_bresp,    // Write response
  output reg           s_axi_bvalid,   // Write response valid
  input  wire          s_axi_bready,   // Write response ready
  input  wire [13:0]   s_axi_araddr,   // Read address
  input  wire          s_axi_arvalid,  // Read address valid
  output reg           s_axi_arready,  // Read address ready
  output reg  [31:0]   s_axi_rdata,    // Read data
  output reg  [1:0]    s_axi_rresp,    // Read response
  output reg           s_axi_rvalid,   // Read data valid
  input  wire          s_axi_rready,   // Read data ready
  input  wire          bus_suspend,    // Bus idle/suspend seen (pin)
  input  wire          bus_resume,     // Host resume seen (pin)
  input  wire          tx_ready,       // Upstream link can send (pin)
  input  wire          radio_evt,      // Radio produced chip-to-host item (pin)
  input  wire [DW-1:0] radio_data,     // Item payload, stable with radio_evt
  output reg           tx_valid,       // Item on tx_data
  output reg  [DW-1:0] tx_data,        // Chip-to-host item
  output reg           remote_wake,    // Remote wake signalling upstream
  output reg           wake_capable,   // Advertised remote wake support
  output reg           self_powered,   // Self-powered descriptor attribute
  output reg           fast_clk_en,    // 48 MHz receive clock enable
  output reg           deep_sleep,     // Deep sleep request
  output reg           radio_enable,   // Radio allowed to run
  output reg           irq             // Interrupt, active high level
);
  localparam [3:0] S_ACTIVE  = 4'b0001;
  localparam [3:0] S_SUSPEND = 4'b0010;
  localparam [3:0] S_WAKE    = 4'b0100;
  localparam [3:0] S_WAITRES = 4'b1000;
  localparam [31:0] WAKE_CYC = `WAKE_SIGNAL_CYC;
  localparam [31:0] WIN_CYC  = `SCAN_WINDOW_CYC;

  function [11:0] word_idx;
    input [13:0] a;
    word_idx = a[13:2];
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Pin synchronisers
  reg [3:0] s1_r, s2_r;
  reg       evt_d_r;
  reg [DW-1:0] data_s1_r;
  reg [DW-1:0] data_r;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_r    <= 4'h0;
      s2_r    <= 4'h0;
      evt_d_r <= 1'b0;
    end else begin
      s1_r    <= {radio_evt, tx_ready, bus_resume, bus_suspend};
      s2_r    <= s1_r;
      evt_d_r <= s2_r[3];
    end
  end
  wire susp_s  = s2_r[0];
  wire res_s   = s2_r[1];
  wire txrdy_s = s2_r[2];
  wire evt_p   = s2_r[3] && !evt_d_r;
  // Payload takes the same two stages as its strobe
  always @(posedge clock) begin
    data_s1_r <= radio_data;
    data_r    <= data_s1_r;
  end

  // Registers
  reg [15:0] self_pwr_r, wake_attr_r;
  reg [1:0]  ctl_r;
  reg [`IRQ_W-1:0] ist_r, imask_r;
  reg [3:0]  st_r;
  reg        ovf_r;

  wire self_pwr = self_pwr_r[0];
  wire wake_cap = wake_attr_r[0];
  wire rw_ok    = wake_cap && self_pwr;
  wire rw_armed = rw_ok && ctl_r[`CTL_WAKE_ENABLE];

  // AXI write
  wire       wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  wire [11:0] widx  = word_idx(s_axi_awaddr);
  wire       w_hit  = (widx == `IDX_SELF_POWERED) || (widx == `IDX_REMOTE_WAKE) ||
                      (widx == `IDX_CONTROL) || (widx == `IDX_IRQ_STATUS) || (widx == `IDX_IRQ_MASK);
  reg [`IRQ_W-1:0] ev_set;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      self_pwr_r    <= `RST_SELF_POWERED;
      wake_attr_r   <= `RST_REMOTE_WAKE;
      ctl_r         <= `RST_CONTROL;
      imask_r       <= {`IRQ_W{1'b0}};
      ist_r         <= {`IRQ_W{1'b0}};
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go && widx == `IDX_SELF_POWERED) begin
        self_pwr_r <= merge16(self_pwr_r, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_go && widx == `IDX_REMOTE_WAKE) begin
        wake_attr_r <= merge16(wake_attr_r, s_axi_wdata, s_axi_wstrb);
      end
      if (wr_go && widx == `IDX_CONTROL && s_axi_wstrb[0]) begin
        ctl_r <= s_axi_wdata[1:0];
      end
      if (wr_go && widx == `IDX_IRQ_MASK && s_axi_wstrb[0]) begin
        imask_r <= s_axi_wdata[`IRQ_W-1:0];
      end
      // Set wins over a simultaneous write-one clear
      if (wr_go && widx == `IDX_IRQ_STATUS && s_axi_wstrb[0]) begin
        ist_r <= (ist_r & ~s_axi_wdata[`IRQ_W-1:0]) | ev_set;
      end else begin
        ist_r <= ist_r | ev_set;
      end
    end
  end

  // Pending store and transmit path
  wire          st_empty, st_full;
  wire [DW-1:0] st_dout;
  // No send on the edge that enters suspend
  wire          can_send = (st_r == S_ACTIVE) && !susp_s && txrdy_s && !tx_valid;
  wire          st_pop   = can_send && !st_empty;
  wire          st_push  = evt_p && radio_enable;

  pending_store #(.WIDTH(DW), .DEPTH(DEPTH), .AW(AW)) u_store (
    .clock (clock),
    .nrst  (nrst),
    .push  (st_push),
    .din   (data_r),
    .pop   (st_pop),
    .dout  (st_dout),
    .empty (st_empty),
    .full  (st_full)
  );

  // Suspend state machine
  reg [31:0] wcnt_r, scnt_r;
  reg [3:0]  st_nxt;
  always @* begin
    st_nxt = st_r;
    case (st_r)
      S_ACTIVE: begin
        if (susp_s) begin
          st_nxt = S_SUSPEND;
        end
      end
      S_SUSPEND: begin
        if (res_s) begin
          st_nxt = S_ACTIVE;
        end else if (rw_armed && !st_empty) begin
          st_nxt = S_WAKE;
        end
      end
      S_WAKE: begin
        if (res_s) begin
          st_nxt = S_ACTIVE;
        end else if (wcnt_r == 32'h0) begin
          st_nxt = S_WAITRES;
        end
      end
      S_WAITRES: begin
        // Traffic stays stored until the host resumes the bus
        if (res_s) begin
          st_nxt = S_ACTIVE;
        end
      end
      default: begin
        st_nxt = S_ACTIVE;
      end
    endcase
  end

  wire in_susp   = (st_nxt != S_ACTIVE);
  wire scan_on   = ctl_r[`CTL_SCAN_ENABLE] && (scnt_r < WIN_CYC);

  // Wake pulse length and scan duty counters
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wcnt_r <= 32'h0;
      scnt_r <= 32'h0;
    end else begin
      if (st_nxt == S_WAKE && st_r != S_WAKE) begin
        wcnt_r <= WAKE_CYC - 32'h1;
      end else if (wcnt_r != 32'h0) begin
        wcnt_r <= wcnt_r - 32'h1;
      end
      // Scan period restarts on every suspend entry
      if (!in_susp || scnt_r >= SCAN_PERIOD - 1) begin
        scnt_r <= 32'h0;
      end else begin
        scnt_r <= scnt_r + 32'h1;
      end
    end
  end

  // Transmit register and sticky overflow; a full store drops the new item
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_valid <= 1'b0;
      tx_data  <= {DW{1'b0}};
      ovf_r    <= 1'b0;
    end else begin
      tx_valid <= st_pop;
      if (st_pop) begin
        tx_data <= st_dout;
      end
      if (st_push && st_full) begin
        ovf_r <= 1'b1;
      end
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r         <= S_ACTIVE;
      remote_wake  <= 1'b0;
      wake_capable <= 1'b0;
      self_powered <= 1'b0;
      fast_clk_en  <= 1'b1;
      deep_sleep   <= 1'b0;
      radio_enable <= 1'b1;
      irq          <= 1'b0;
    end else begin
      st_r         <= st_nxt;
      remote_wake  <= (st_nxt == S_WAKE);
      wake_capable <= wake_cap;
      self_powered <= self_pwr;
      fast_clk_en  <= !in_susp;
      // Self-powered radio runs in suspend; idle scans sleep between windows
      if (!in_susp) begin
        radio_enable <= 1'b1;
        deep_sleep   <= 1'b0;
      end else if (!self_pwr) begin
        radio_enable <= 1'b0;
        deep_sleep   <= 1'b1;
      end else if (rw_armed) begin
        radio_enable <= 1'b1;
        deep_sleep   <= !scan_on;
      end else begin
        radio_enable <= 1'b1;
        deep_sleep   <= !scan_on;
      end
      irq <= |(ist_r & imask_r);
    end
  end

  always @* begin
    ev_set = {`IRQ_W{1'b0}};
    ev_set[`IRQ_SUSPEND]     = (st_r == S_ACTIVE) && (st_nxt == S_SUSPEND);
    ev_set[`IRQ_RESUME]      = (st_r != S_ACTIVE) && (st_nxt == S_ACTIVE);
    ev_set[`IRQ_REMOTE_WAKE] = (st_r != S_WAKE) && (st_nxt == S_WAKE);
    ev_set[`IRQ_OVERFLOW]    = evt_p && radio_enable && st_full;
  end

  // AXI read
  wire [11:0] ridx = word_idx(s_axi_araddr);
  reg  [6:0]  stat;
  always @* begin
    stat                  = 7'h00;
    stat[`ST_SUSPENDED]   = (st_r != S_ACTIVE);
    stat[`ST_RADIO_ON]    = radio_enable;
    stat[`ST_DEEP_SLEEP]  = deep_sleep;
    stat[`ST_WAKE_SIGNAL] = remote_wake;
    stat[`ST_PENDING]     = !st_empty;
    stat[`ST_FAST_CLK]    = fast_clk_en;
    stat[`ST_OVERFLOW]    = ovf_r;
  end
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (ridx)
          `IDX_SELF_POWERED: s_axi_rdata <= {16'h0, self_pwr_r};
          `IDX_REMOTE_WAKE:  s_axi_rdata <= {16'h0, wake_attr_r};
          `IDX_CONTROL:      s_axi_rdata <= {30'h0, ctl_r};
          `IDX_STATUS:       s_axi_rdata <= {25'h0, stat};
          `IDX_IRQ_STATUS:   s_axi_rdata <= {28'h0, ist_r};
          `IDX_IRQ_MASK:     s_axi_rdata <= {28'h0, imask_r};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // usb_suspend_remote_wake_ctrl

// >>> verilog/usb_pm_map.vh
// Purpose: register map, field positions, reset values and timing for suspend/wake control
// Assumes: AXI4-Lite byte addresses are four times the register index
// Notes:   definitions only
`ifndef USB_PM_MAP_VH
`define USB_PM_MAP_VH

// Register indices as printed
`define IDX_SELF_POWERED     12'h3F2
`define IDX_REMOTE_WAKE      12'h3F3
`define IDX_CONTROL          12'h3F4
`define IDX_STATUS           12'h3F5
`define IDX_IRQ_STATUS       12'h3F6
`define IDX_IRQ_MASK         12'h3F7
`define ADDR_W               14

// Control fields
`define CTL_WAKE_ENABLE      0
`define CTL_SCAN_ENABLE      1

// Status fields
`define ST_SUSPENDED         0
`define ST_RADIO_ON          1
`define ST_DEEP_SLEEP        2
`define ST_WAKE_SIGNAL       3
`define ST_PENDING           4
`define ST_FAST_CLK          5
`define ST_OVERFLOW          6

// Interrupt fields
`define IRQ_SUSPEND          0
`define IRQ_RESUME           1
`define IRQ_REMOTE_WAKE      2
`define IRQ_OVERFLOW         3
`define IRQ_W                4

// Reset values
`define RST_SELF_POWERED     16'h0000
`define RST_REMOTE_WAKE      16'h0000
`define RST_CONTROL          2'h0

// Timing
`define CLK_MHZ              125
`define BUS_RATE_MHZ         12
`define RX_CLK_RATIO         4
`define WAKE_SIGNAL_US       1
`define WAKE_SIGNAL_CYC      (`WAKE_SIGNAL_US * `CLK_MHZ)
`define SCAN_PERIOD_US       1280
`define SCAN_PERIOD_CYC      (`SCAN_PERIOD_US * `CLK_MHZ)
`define SCAN_WINDOW_US       11
`define SCAN_WINDOW_CYC      (`SCAN_WINDOW_US * `CLK_MHZ)

`endif

// >>> verilog/pending_store.v
// Purpose: holds chip-to-host words produced while the bus cannot carry them
// Assumes: one clock; push and pop come from same-domain logic
// Notes:   flip-flop storage addressed by index; full refuses, never overwrites
`timescale 1ns/1ps
module pending_store #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clock,   // System clock
  input  wire             nrst,    // Async reset, active low
  input  wire             push,    // Write one word
  input  wire [WIDTH-1:0] din,     // Word written
  input  wire             pop,     // Take head word
  output wire [WIDTH-1:0] dout,    // Head word
  output wire             empty,   // Nothing held
  output wire             full     // No room
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_r;
  reg [AW-1:0]    rd_r;
  reg [AW:0]      cnt_r;

  wire do_push = push && !full;
  wire do_pop  = pop && !empty;

  assign empty = (cnt_r == {(AW+1){1'b0}});
  assign full  = (cnt_r == DEPTH[AW:0]);
  assign dout  = mem_r[rd_r];

  always @(posedge clock) begin
    if (do_push) begin
      mem_r[wr_r] <= din;
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (do_pop) begin
        rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end
endmodule // pending_store

// >>> verif/usb_pm_chk.sv
// Purpose: port-level checks for the suspend and remote wake controller
// Assumes: suspended exactly while fast_clk_en is low
// Notes:   bound to the top module at the foot of this file
`timescale 1ns/1ps
module usb_pm_chk (
  input wire clock,          // System clock
  input wire nrst,           // Reset, active low
  input wire s_axi_awready,  // Write address ready
  input wire s_axi_wready,   // Write data ready
  input wire s_axi_bvalid,   // Write response valid
  input wire s_axi_arready,  // Read address ready
  input wire s_axi_rvalid,   // Read data valid
  input wire tx_valid,       // Item sent upstream
  input wire remote_wake,    // Wake signalling
  input wire wake_capable,   // Advertised wake support
  input wire self_powered,   // Power attribute
  input wire fast_clk_en,    // Receive clock enable
  input wire deep_sleep,     // Deep sleep request
  input wire radio_enable    // Radio allowed
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [7:0] wake_cnt_r;
  // Counts high cycles of the wake pulse, read when it falls
  always @(posedge clock or negedge nrst) begin
    if (!nrst) wake_cnt_r <= 8'h00;
    else wake_cnt_r <= remote_wake ? wake_cnt_r + 8'h01 : 8'h00;
  end
  sequence s_bp_enter;
    !self_powered && $fell(fast_clk_en);
  endsequence
  sequence s_sp_enter;
    self_powered && $fell(fast_clk_en);
  endsequence
  a_bus_halt: assert property (s_bp_enter |-> ##[0:3] (!radio_enable && deep_sleep))
    else $error("radio not halted in bus-powered suspend");
  a_self_radio: assert property (s_sp_enter |-> radio_enable [*8])
    else $error("radio stopped in self-powered suspend");
  a_wake_attr: assert property ($rose(remote_wake) |-> wake_capable && self_powered && !fast_clk_en)
    else $error("remote wake without both attributes in suspend");
  a_wake_len: assert property ($fell(remote_wake) |-> wake_cnt_r == 8'h7D)
    else $error("remote wake length wrong");
  a_no_tx_susp: assert property (tx_valid |-> fast_clk_en)
    else $error("item sent while suspended");
  a_tx_space: assert property (tx_valid |=> !tx_valid)
    else $error("items sent back to back");
  a_sleep_clk: assert property (deep_sleep |-> !fast_clk_en)
    else $error("deep sleep with fast clock running");
  a_write_resp: assert property ($rose(s_axi_bvalid) |-> s_axi_awready && s_axi_wready)
    else $error("write response without address and data taken");
  a_read_resp: assert property ($rose(s_axi_rvalid) |-> s_axi_arready)
    else $error("read data without address taken");
endmodule // usb_pm_chk
bind usb_suspend_remote_wake_ctrl usb_pm_chk u_pm_chk (.clock, .nrst, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .tx_valid, .remote_wake, .wake_capable, .self_powered,
  .fast_clk_en, .deep_sleep, .radio_enable);

// >>> verif/usb_host_model.sv
// Purpose: behavioural host and hub side of the suspend link
// Assumes: bench pulses go_suspend and go_resume for one cycle
// Notes:   answers an ended wake with a resume after resume_delay cycles
`timescale 1ns/1ps
module usb_host_model (
  input  wire logic       clock,         // System clock
  input  wire logic       nrst,          // Reset, active low
  input  wire logic       go_suspend,    // Bench asks for suspend
  input  wire logic       go_resume,     // Bench asks for resume
  input  wire logic       remote_wake,   // Wake signalling from device
  input  wire logic [7:0] resume_delay,  // Host reaction time
  output logic            bus_suspend,   // Bus in suspend
  output logic            bus_resume,    // Resume signalling
  output logic            tx_ready       // Upstream takes items
);
  logic [8:0] cnt_r;
  logic       wake_seen_r;
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 9'h000;
      wake_seen_r <= 1'b0;
      bus_suspend <= 1'b0;
      bus_resume <= 1'b0;
      tx_ready <= 1'b1;
    end else begin
      if (remote_wake) wake_seen_r <= 1'b1;
      // Never resumes on its own, only on request or an ended wake
      if ((go_resume || (wake_seen_r && !remote_wake)) && cnt_r == 9'h000) begin
        cnt_r <= {1'b0, resume_delay} + 9'h00A;
        wake_seen_r <= 1'b0;
      end else if (cnt_r != 9'h000) begin
        cnt_r <= cnt_r - 9'h001;
      end
      bus_resume <= (cnt_r != 9'h000) && (cnt_r <= 9'h00A);
      if (cnt_r == 9'h00A) bus_suspend <= 1'b0;
      if (cnt_r == 9'h001) tx_ready <= 1'b1;
      // Suspend request raises bus_suspend and stops taking items
      if (go_suspend) begin
        bus_suspend <= 1'b1;
        tx_ready <= 1'b0;
      end
    end
  end
endmodule // usb_host_model

// >>> verif/usb_suspend_remote_wake_ctrl_bench.sv
// Purpose: scenario bench for the suspend and remote wake controller
// Assumes: byte address is four times the register index
// Notes:   scan period shortened so a scan cycle fits the run
`timescale 1ns/1ps
`include "usb_pm_map.vh"
module usb_suspend_remote_wake_ctrl_bench;
  logic        clock, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  logic        go_suspend, go_resume, radio_evt, wake_prev;
  logic [7:0]  radio_data, resume_delay;
  wire         bus_suspend, bus_resume, tx_ready, tx_valid, remote_wake, wake_capable, self_powered;
  wire         fast_clk_en, deep_sleep, radio_enable, irq;
  wire  [7:0]  tx_data;
  int          bad_count, check_count, cycles, wake_count, k;
  logic [7:0]  txq[$];
  usb_suspend_remote_wake_ctrl #(.SCAN_PERIOD(2000)) u_usb_suspend_remote_wake_ctrl (.clock, .nrst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_suspend, .bus_resume, .tx_ready, .radio_evt,
    .radio_data, .tx_valid, .tx_data, .remote_wake, .wake_capable, .self_powered, .fast_clk_en,
    .deep_sleep, .radio_enable, .irq);
  usb_host_model u_usb_host_model (.clock, .nrst, .go_suspend, .go_resume, .remote_wake, .resume_delay,
    .bus_suspend, .bus_resume, .tx_ready);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task final_report;
    $display("comparisons %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard; also collects sent items and counts wake pulses
  always @(posedge clock) begin
    cycles++;
    if (tx_valid === 1'b1) txq.push_back(tx_data);
    if (remote_wake === 1'b1 && wake_prev !== 1'b1) wake_count++;
    wake_prev <= remote_wake;
    if (cycles == 60000) begin
      bad_count++;
      final_report;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task axi_wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask
  task axi_rd(input logic [11:0] idx, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (s_axi_rvalid !== 1'b1) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    check(s_axi_rresp, er);
    if (er == 2'b00) check(s_axi_rdata, exp);
  endtask
  task radio(input logic [7:0] d);
    @(posedge clock);
    radio_data <= d;
    radio_evt <= 1'b1;
    repeat (4) @(posedge clock);
    radio_evt <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
  task suspend_bus;
    @(posedge clock);
    go_suspend <= 1'b1;
    @(posedge clock);
    go_suspend <= 1'b0;
    repeat (10) @(posedge clock);
  endtask
  task resume_bus;
    @(posedge clock);
    go_resume <= 1'b1;
    @(posedge clock);
    go_resume <= 1'b0;
    while (fast_clk_en !== 1'b1) @(posedge clock);
    repeat (10) @(posedge clock);
  endtask
  task t_reset_map;
    check(fast_clk_en, 1);
    check(self_powered, 0);
    axi_rd(`IDX_SELF_POWERED, 0, 0);
    axi_rd(`IDX_REMOTE_WAKE, 0, 0);
    axi_rd(12'h3FF, 0, 2);
    axi_wr(12'h3FF, 1, 2);
  endtask
  task t_bus_powered;
    axi_wr(`IDX_IRQ_MASK, 1, 0);
    suspend_bus;
    check(radio_enable, 0);
    check(deep_sleep, 1);
    check(irq, 1);
    radio(8'h5A);
    repeat (300) @(posedge clock);
    check(fast_clk_en, 0);
    axi_rd(`IDX_STATUS, 32'h5, 0);
    axi_rd(`IDX_IRQ_STATUS, 32'h1, 0);
    axi_wr(`IDX_IRQ_STATUS, 1, 0);
    repeat (2) @(posedge clock);
    check(irq, 0);
    axi_wr(`IDX_IRQ_MASK, 0, 0);
    resume_bus;
    check(fast_clk_en, 1);
    check(txq.size(), 0);
  endtask
  task t_self_no_wake;
    axi_wr(`IDX_SELF_POWERED, 1, 0);
    axi_wr(`IDX_CONTROL, 1, 0);
    repeat (2) @(posedge clock);
    check({wake_capable, self_powered}, 2'b01);
    suspend_bus;
    check(radio_enable, 1);
    repeat (9) radio(8'hC3);
    repeat (300) @(posedge clock);
    check(fast_clk_en, 0);
    check(txq.size(), 0);
    axi_rd(`IDX_STATUS, 32'h57, 0);
    resume_bus;
    repeat (20) @(posedge clock);
    check(txq.size(), 8);
    check(txq.pop_front(), 8'hC3);
    txq.delete();
  endtask
  task t_remote_wake(input int pass);
    int n;
    resume_delay <= pass ? 8'hC8 : 8'h00;
    axi_wr(`IDX_REMOTE_WAKE, 1, 0);
    repeat (2) @(posedge clock);
    check(wake_capable, 1);
    suspend_bus;
    radio(8'h11);
    radio(8'h22);
    radio(8'h33);
    check(radio_enable, 1);
    for (n = 0; n < 2000 && txq.size() < 3; n++) @(posedge clock);
    check(wake_count, pass + 1);
    check(txq.size(), 3);
    check({txq[0], txq[1], txq[2]}, 24'h112233);
    txq.delete();
  endtask
  task t_scan;
    int hi, lo;
    axi_wr(`IDX_CONTROL, 3, 0);
    suspend_bus;
    hi = 0;
    lo = 0;
    repeat (5000) begin
      @(posedge clock);
      if (deep_sleep === 1'b1) hi++;
      if (deep_sleep === 1'b0) lo++;
    end
    check(hi > 0 && lo > 0, 1);
    resume_bus;
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 60'h0;
    s_axi_wstrb = 4'hF;
    {go_suspend, go_resume, radio_evt, radio_data, resume_delay} = 19'h0;
    nrst = 1'b0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    t_reset_map;
    t_bus_powered;
    t_self_no_wake;
    for (k = 0; k < 2; k++) t_remote_wake(k);
    t_scan;
    final_report;
  end
endmodule // usb_suspend_remote_wake_ctrl_bench
